/* tsc_cfg.svh */
// Constants for the two-wire register access slave: addresses, counts and timing.
`ifndef TSC_CFG_SVH
`define TSC_CFG_SVH

// ==========================================================================
// Slave address selected by the strap
// ==========================================================================
`define TSC_SLV_ADDR_LO 7'h40
`define TSC_SLV_ADDR_HI 7'h41
`define TSC_DIR_READ 1'b1

// ==========================================================================
// Register space layout
// ==========================================================================
`define TSC_FIRST_ADDR 8'h00
`define TSC_LAST_ADDR 8'hFF
`define TSC_NOINC_LO 8'hF0
`define TSC_NOINC_HI 8'hFF

// ==========================================================================
// Framing and timing
// ==========================================================================
`define TSC_LAST_BIT 4'h7
`define TSC_ACK_MARK 4'h8
`define TSC_STRAP_WAIT 2'h2
`define TSC_CLK_NS 100
`define TSC_T_LOW_NS 1300
`define TSC_T_LOW_CYC (`TSC_T_LOW_NS / `TSC_CLK_NS)

`endif

/* tsc_pkg.sv */
// Types shared by the two-wire register access slave.
package tsc_pkg;

  // ========================================================================
  // Protocol state machine
  // ========================================================================
  typedef enum logic [2:0] {
    TSC_IDLE,
    TSC_DEVADDR,
    TSC_REGADDR,
    TSC_WDATA,
    TSC_ACK,
    TSC_RDATA,
    TSC_RACK
  } tsc_state_t;

endpackage

/* tsc_pins_if.sv */
// Interface carrying synchronised bus levels and detected bus events.
`timescale 1ns/1ns

interface tsc_pins_if;
  logic scl_q;
  logic sda_q;
  logic strap_q;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  modport prod (output scl_q, sda_q, strap_q, scl_rise, scl_fall, start_det, stop_det);
  modport cons (input scl_q, sda_q, strap_q, scl_rise, scl_fall, start_det, stop_det);
endinterface

/* tsc_pin_sync.sv */
// Pin synchroniser and start, stop and clock edge detector.
`timescale 1ns/1ns
`include "tsc_cfg.svh"

module tsc_pin_sync
  import tsc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Raw pins
  input wire logic serial_clock_i,
  input wire logic serial_data_line_i,
  input wire logic address_strap_pin_i,
  // Events to the protocol engine
  tsc_pins_if.prod p
);

  // Bit 0 clock, bit 1 data, bit 2 strap.
  logic [2:0] meta_ff;
  logic [2:0] sync_ff;
  logic [1:0] prev_ff;
  logic [2:0] nxt_meta;
  logic [2:0] nxt_sync;
  logic [1:0] nxt_prev;

  // ========================================================================
  // Two-flop synchronisers plus one history stage for edge detection
  // ========================================================================
  // Only the second stage and the history stage feed any logic.
  always_comb
  begin
    nxt_meta = {address_strap_pin_i, serial_data_line_i, serial_clock_i};
    nxt_sync = meta_ff;
    nxt_prev = sync_ff[1:0];
  end

  // Idle bus level is high, so the clock and data bits reset to ones to avoid a false event; the strap bit resets to zero.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_ff <= 3'h3;
      sync_ff <= 3'h3;
      prev_ff <= 2'h3;
    end
    else
    begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
      prev_ff <= nxt_prev;
    end
  end

  // Data edges while the clock stays high mark start and stop.
  assign p.scl_q = sync_ff[0];
  assign p.sda_q = sync_ff[1];
  assign p.strap_q = sync_ff[2];
  assign p.scl_rise = sync_ff[0] & ~prev_ff[0];
  assign p.scl_fall = ~sync_ff[0] & prev_ff[0];
  assign p.start_det = sync_ff[0] & prev_ff[0] & prev_ff[1] & ~sync_ff[1];
  assign p.stop_det = sync_ff[0] & prev_ff[0] & ~prev_ff[1] & sync_ff[1];

  // ========================================================================
  // Checks
  // ========================================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_start_shape;
    p.start_det |-> $past(p.sda_q) && !p.sda_q && p.scl_q && $past(p.scl_q);
  endproperty
  a_start_shape: assert property (p_start_shape) else $error("start seen without data fall under high clock");

  property p_stop_shape;
    p.stop_det |-> !$past(p.sda_q) && p.sda_q && p.scl_q && $past(p.scl_q);
  endproperty
  a_stop_shape: assert property (p_stop_shape) else $error("stop seen without data rise under high clock");

endmodule // tsc_pin_sync

/* tsc_i2c_slave.sv */
// Two-wire serial slave giving a master access to the register space.
`timescale 1ns/1ns
`include "tsc_cfg.svh"

module tsc_i2c_slave
  import tsc_pkg::*;
#(
  parameter logic [7:0] LAST_ADDR = `TSC_LAST_ADDR,
  parameter logic [7:0] NOINC_LO = `TSC_NOINC_LO,
  parameter logic [7:0] NOINC_HI = `TSC_NOINC_HI
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Serial bus pins
  input wire logic serial_clock_i,
  input wire logic serial_data_line_i,
  output logic serial_data_line_o,
  output logic serial_data_line_oe,
  // Address strap
  input wire logic address_strap_pin_i,
  // Register space port
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Status
  output logic selected
);

  tsc_pins_if pins ();

  tsc_state_t state_ff;
  tsc_state_t nxt_state;
  tsc_state_t after_ff;
  tsc_state_t nxt_after;
  logic [3:0] bit_cnt_ff;
  logic [3:0] nxt_bit_cnt;
  logic [7:0] shift_ff;
  logic [7:0] nxt_shift;
  logic [7:0] addr_cnt_ff;
  logic [7:0] nxt_addr_cnt;
  logic inc_pend_ff;
  logic nxt_inc_pend;
  logic oe_ff;
  logic nxt_oe;
  logic wr_ff;
  logic nxt_wr;
  logic [7:0] wdata_ff;
  logic [7:0] nxt_wdata;
  logic rd_ff;
  logic nxt_rd;
  logic sel_ff;
  logic nxt_sel;
  logic [1:0] strap_cnt_ff;
  logic [1:0] nxt_strap_cnt;
  logic strap_done_ff;
  logic nxt_strap_done;
  logic [6:0] own_addr_ff;
  logic [6:0] nxt_own_addr;
  logic [7:0] rx_byte;

  // ========================================================================
  // Address counter stepping
  // ========================================================================
  // Holds inside the fixed window, otherwise steps and wraps after the top.
  function automatic logic [7:0] step_addr(input logic [7:0] a);
    if ((a >= NOINC_LO) && (a <= NOINC_HI))
      return a;
    else if (a == LAST_ADDR)
      return `TSC_FIRST_ADDR;
    else
      return a + 8'h01;
  endfunction

  // ========================================================================
  // Pin synchroniser
  // ========================================================================
  // Latency is two clocks, well inside the shortest low phase at 400 Kbps.
  tsc_pin_sync u_sync (
    .clk(clk),
    .resetn(resetn),
    .serial_clock_i(serial_clock_i),
    .serial_data_line_i(serial_data_line_i),
    .address_strap_pin_i(address_strap_pin_i),
    .p(pins.prod)
  );

  // The byte as it stands once the current bit is shifted in.
  assign rx_byte = {shift_ff[6:0], pins.sda_q};

  // ========================================================================
  // Strap capture
  // ========================================================================
  // Wait for the synchroniser to fill, sample once, then ignore the pin.
  always_comb
  begin
    nxt_strap_cnt = strap_cnt_ff;
    nxt_strap_done = strap_done_ff;
    nxt_own_addr = own_addr_ff;
    if (!strap_done_ff)
    begin
      if (strap_cnt_ff == `TSC_STRAP_WAIT)
      begin
        nxt_strap_done = 1'b1;
        nxt_own_addr = pins.strap_q ? `TSC_SLV_ADDR_HI : `TSC_SLV_ADDR_LO;
      end
      else
        nxt_strap_cnt = strap_cnt_ff + 2'h1;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      strap_cnt_ff <= 2'h0;
      strap_done_ff <= 1'b0;
      own_addr_ff <= `TSC_SLV_ADDR_LO;
    end
    else
    begin
      strap_cnt_ff <= nxt_strap_cnt;
      strap_done_ff <= nxt_strap_done;
      own_addr_ff <= nxt_own_addr;
    end
  end

  // ========================================================================
  // Protocol engine
  // ========================================================================
  // Data is driven only on falling clock edges, so the data line never
  // moves under a high clock and no false start or stop is produced.
  always_comb
  begin
    nxt_state = state_ff;
    nxt_after = after_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_shift = shift_ff;
    nxt_addr_cnt = addr_cnt_ff;
    nxt_inc_pend = inc_pend_ff;
    nxt_oe = oe_ff;
    nxt_wr = 1'b0;
    nxt_wdata = wdata_ff;
    nxt_rd = 1'b0;
    if (pins.stop_det)
    begin
      nxt_state = TSC_IDLE;
      nxt_oe = 1'b0;
      nxt_inc_pend = 1'b0;
    end
    else if (pins.start_det && strap_done_ff)
    begin
      nxt_state = TSC_DEVADDR;
      nxt_bit_cnt = 4'h0;
      nxt_oe = 1'b0;
      nxt_inc_pend = 1'b0;
    end
    else
    begin
      case (state_ff)
        TSC_IDLE:
        begin
          nxt_oe = 1'b0;
        end
        TSC_DEVADDR, TSC_REGADDR, TSC_WDATA:
        begin
          if (pins.scl_rise)
          begin
            nxt_shift = rx_byte;
            nxt_bit_cnt = bit_cnt_ff + 4'h1;
            if (bit_cnt_ff == `TSC_LAST_BIT)
            begin
              nxt_state = TSC_ACK;
              nxt_bit_cnt = 4'h0;
              if (state_ff == TSC_DEVADDR)
              begin
                if (rx_byte[7:1] != own_addr_ff)
                  nxt_state = TSC_IDLE;
                else if (rx_byte[0] == `TSC_DIR_READ)
                  nxt_after = TSC_RDATA;
                else
                  nxt_after = TSC_REGADDR;
              end
              else if (state_ff == TSC_REGADDR)
              begin
                nxt_addr_cnt = rx_byte;
                nxt_after = TSC_WDATA;
              end
              else
              begin
                nxt_wr = 1'b1;
                nxt_wdata = rx_byte;
                nxt_inc_pend = 1'b1;
                nxt_after = TSC_WDATA;
              end
            end
          end
        end
        TSC_ACK:
        begin
          // First fall drives the acknowledge, the second ends it.
          if (pins.scl_fall)
          begin
            if (!oe_ff)
              nxt_oe = 1'b1;
            else
            begin
              nxt_oe = 1'b0;
              nxt_state = after_ff;
              nxt_bit_cnt = 4'h0;
              if (inc_pend_ff)
                nxt_addr_cnt = step_addr(addr_cnt_ff);
              nxt_inc_pend = 1'b0;
              if (after_ff == TSC_RDATA)
              begin
                nxt_shift = reg_rdata;
                nxt_oe = ~reg_rdata[7];
                nxt_rd = 1'b1;
              end
            end
          end
        end
        TSC_RDATA:
        begin
          if (pins.scl_fall)
          begin
            if (bit_cnt_ff == `TSC_LAST_BIT)
            begin
              nxt_oe = 1'b0;
              nxt_state = TSC_RACK;
              nxt_bit_cnt = 4'h0;
              nxt_addr_cnt = step_addr(addr_cnt_ff);
            end
            else
            begin
              nxt_shift = {shift_ff[6:0], 1'b0};
              nxt_oe = ~shift_ff[6];
              nxt_bit_cnt = bit_cnt_ff + 4'h1;
            end
          end
        end
        TSC_RACK:
        begin
          if (pins.scl_rise)
          begin
            if (pins.sda_q)
              nxt_state = TSC_IDLE;
            else
              nxt_bit_cnt = `TSC_ACK_MARK;
          end
          else if (pins.scl_fall && (bit_cnt_ff == `TSC_ACK_MARK))
          begin
            nxt_state = TSC_RDATA;
            nxt_bit_cnt = 4'h0;
            nxt_shift = reg_rdata;
            nxt_oe = ~reg_rdata[7];
            nxt_rd = 1'b1;
          end
        end
        default:
        begin
          nxt_state = TSC_IDLE;
          nxt_oe = 1'b0;
        end
      endcase
    end
    nxt_sel = (nxt_state != TSC_IDLE);
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_ff <= TSC_IDLE;
      after_ff <= TSC_IDLE;
      bit_cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      addr_cnt_ff <= `TSC_FIRST_ADDR;
      inc_pend_ff <= 1'b0;
      oe_ff <= 1'b0;
      wr_ff <= 1'b0;
      wdata_ff <= 8'h00;
      rd_ff <= 1'b0;
      sel_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      after_ff <= nxt_after;
      bit_cnt_ff <= nxt_bit_cnt;
      shift_ff <= nxt_shift;
      addr_cnt_ff <= nxt_addr_cnt;
      inc_pend_ff <= nxt_inc_pend;
      oe_ff <= nxt_oe;
      wr_ff <= nxt_wr;
      wdata_ff <= nxt_wdata;
      rd_ff <= nxt_rd;
      sel_ff <= nxt_sel;
    end
  end

  // ========================================================================
  // Outputs
  // ========================================================================
  // Open drain: the data output is always low, only the enable moves.
  assign serial_data_line_o = 1'b0;
  assign serial_data_line_oe = oe_ff;
  assign reg_addr = addr_cnt_ff;
  assign reg_wr = wr_ff;
  assign reg_wdata = wdata_ff;
  assign reg_rd = rd_ff;
  assign selected = sel_ff;

  // ========================================================================
  // Checks
  // ========================================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_addr_miss;
    state_ff == TSC_DEVADDR && pins.scl_rise && !pins.stop_det && !pins.start_det &&
      bit_cnt_ff == `TSC_LAST_BIT && rx_byte[7:1] != own_addr_ff |=> state_ff == TSC_IDLE && !oe_ff;
  endproperty
  a_addr_miss: assert property (p_addr_miss) else $error("foreign address not ignored");

  property p_strap_pick;
    $rose(strap_done_ff) |-> own_addr_ff == ($past(pins.strap_q) ? `TSC_SLV_ADDR_HI : `TSC_SLV_ADDR_LO);
  endproperty
  a_strap_pick: assert property (p_strap_pick) else $error("slave address does not follow strap");

  property p_strap_hold;
    strap_done_ff && $past(strap_done_ff) |-> $stable(own_addr_ff);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("slave address changed after capture");

  property p_start_enter;
    pins.start_det && strap_done_ff && !pins.stop_det |=> state_ff == TSC_DEVADDR && bit_cnt_ff == 4'h0;
  endproperty
  a_start_enter: assert property (p_start_enter) else $error("start did not open address phase");

  property p_idle_quiet;
    state_ff == TSC_IDLE && !pins.start_det |=> state_ff == TSC_IDLE && !oe_ff;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("activity without start");

  property p_stop_idle;
    pins.stop_det |=> state_ff == TSC_IDLE && !serial_data_line_oe && !selected;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop did not return to idle");

  property p_oe_on_fall;
    $changed(oe_ff) && !$past(pins.stop_det) && !$past(pins.start_det) |-> $past(pins.scl_fall);
  endproperty
  a_oe_on_fall: assert property (p_oe_on_fall) else $error("data drive changed off a clock fall");

  property p_nack_idle;
    state_ff == TSC_RACK && pins.scl_rise && pins.sda_q && !pins.stop_det && !pins.start_det
      |=> state_ff == TSC_IDLE ##1 !oe_ff;
  endproperty
  a_nack_idle: assert property (p_nack_idle) else $error("no-ack did not end the read");

  property p_wr_ack;
    reg_wr |-> state_ff == TSC_ACK && !oe_ff && reg_wdata == shift_ff;
  endproperty
  a_wr_ack: assert property (p_wr_ack) else $error("written byte not followed by acknowledge");

  property p_rd_wrap;
    state_ff == TSC_RDATA && pins.scl_fall && bit_cnt_ff == `TSC_LAST_BIT && !pins.stop_det &&
      !pins.start_det && addr_cnt_ff == LAST_ADDR && !(LAST_ADDR >= NOINC_LO && LAST_ADDR <= NOINC_HI)
      |=> reg_addr == `TSC_FIRST_ADDR;
  endproperty
  a_rd_wrap: assert property (p_rd_wrap) else $error("read counter did not wrap");

  property p_regaddr_load;
    state_ff == TSC_REGADDR && pins.scl_rise && bit_cnt_ff == `TSC_LAST_BIT && !pins.stop_det &&
      !pins.start_det |=> reg_addr == $past(rx_byte);
  endproperty
  a_regaddr_load: assert property (p_regaddr_load) else $error("register address not loaded");

  c_write: cover property (reg_wr ##[1:300] state_ff == TSC_WDATA);
  c_read_more: cover property (state_ff == TSC_RACK ##[1:300] reg_rd);
  c_nack: cover property (state_ff == TSC_RACK ##1 state_ff == TSC_IDLE);
  c_miss: cover property (state_ff == TSC_DEVADDR ##1 state_ff == TSC_IDLE);

endmodule // tsc_i2c_slave

/* tsc_bus_master.sv */
// Two-wire bus master model that drives the slave from the bench.
`timescale 1ns/1ns

module tsc_bus_master
(
  // Clock
  input wire logic clk,
  // Resolved data line level
  input wire logic sda,
  // Open-drain pulls, high while the line is held low
  output logic scl_pull,
  output logic sda_pull
);
  // ==========================================================================
  // Bus phase lengths in system clock cycles
  // ==========================================================================
  int lo = 13;
  int hi = 12;

  // Both lines start released, so the pull-ups hold them high.
  initial
  begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
  end

  // Waits a number of system clock edges.
  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Data moves two cycles after the clock falls, so it never races that fall.
  task automatic bit_io(input logic b, output logic r);
    scl_pull <= 1'b1;
    w(2);
    sda_pull <= ~b;
    w(lo - 2);
    scl_pull <= 1'b0;
    w(hi);
    r = sda;
  endtask

  // Start when p is low, stop when p is high: data toggles while the clock is high.
  task automatic cond(input logic p);
    scl_pull <= 1'b1;
    w(2);
    sda_pull <= p;
    w(lo - 2);
    scl_pull <= 1'b0;
    w(hi);
    sda_pull <= ~p;
    w(hi);
  endtask

  // A byte MSB first and the ninth bit; a released bit reads what the slave drives.
  task automatic xfer(input logic [7:0] tx, input logic nine, output logic [7:0] rx, output logic n9);
    for (int i = 7; i >= 0; i--)
      bit_io(tx[i], rx[i]);
    bit_io(nine, n9);
  endtask
endmodule // tsc_bus_master

/* tsc_i2c_slave_bench.sv */
// Self-checking bench for the two-wire register access slave.
`timescale 1ns/1ns

module tsc_i2c_slave_bench;
  // ==========================================================================
  // Signals
  // ==========================================================================
  logic clk;
  logic resetn;
  logic strap;
  logic m_scl;
  logic m_sda;
  wire logic scl_w;
  wire logic sda_w;
  logic sda_o;
  logic sda_oe;
  logic [7:0] reg_addr;
  logic reg_wr;
  logic [7:0] reg_wdata;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic selected;
  logic [7:0] mem [256];
  logic [6:0] own;
  int wr_cnt;
  int rd_cnt;
  int err_count;
  int checked;

  // Open-drain lines with pull-ups: any party pulling wins.
  assign scl_w = ~m_scl;
  assign sda_w = ~(m_sda | (sda_oe & ~sda_o));
  assign reg_rdata = mem[reg_addr];

  // The hold window is moved low so that the wrap point can be reached beside it.
  tsc_i2c_slave #(
    .LAST_ADDR(8'hFF),
    .NOINC_LO(8'h21),
    .NOINC_HI(8'h22)
  ) DUT (
    .clk(clk),
    .resetn(resetn),
    .serial_clock_i(scl_w),
    .serial_data_line_i(sda_w),
    .serial_data_line_o(sda_o),
    .serial_data_line_oe(sda_oe),
    .address_strap_pin_i(strap),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_wdata(reg_wdata),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .selected(selected)
  );

  tsc_bus_master M (
    .clk(clk),
    .sda(sda_w),
    .scl_pull(m_scl),
    .sda_pull(m_sda)
  );

  // Register space model; write and fetch pulses are counted so that refused traffic shows up.
  always @(posedge clk)
  begin
    if (reg_wr === 1'b1)
    begin
      mem[reg_addr] <= reg_wdata;
      wr_cnt <= wr_cnt + 1;
    end
    if (reg_rd === 1'b1)
      rd_cnt <= rd_cnt + 1;
  end

  // A 10 MHz system clock.
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic close_out;
    if (err_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Start, own address for writing and the register address; the bus is kept for more bytes.
  task automatic head(input logic [7:0] ra);
    logic [7:0] rx;
    logic a;
    M.cond(1'b0);
    M.xfer({own, 1'b0}, 1'b1, rx, a);
    check({7'h00, a}, 8'h00, "address ack");
    M.xfer(ra, 1'b1, rx, a);
    check({7'h00, a}, 8'h00, "register address ack");
    check({7'h00, selected}, 8'h01, "selected in transfer");
  endtask

  task automatic wr2(input logic [7:0] ra, input logic [7:0] d0, input logic [7:0] d1);
    logic [7:0] rx;
    logic a;
    logic b;
    head(ra);
    M.xfer(d0, 1'b1, rx, a);
    M.xfer(d1, 1'b1, rx, b);
    M.cond(1'b1);
    check({6'h00, a, b}, 8'h00, "data acks");
    check({7'h00, selected}, 8'h00, "idle after stop");
  endtask

  // The byte after the last one has bit 7 low, so a slave that kept sending would pull the line.
  task automatic rd2(input logic [7:0] ra, output logic [7:0] r0, output logic [7:0] r1);
    logic a;
    int n;
    n = rd_cnt;
    head(ra);
    M.cond(1'b0);
    M.xfer({own, 1'b1}, 1'b1, r0, a);
    check({7'h00, a}, 8'h00, "read address ack");
    M.xfer(8'hFF, 1'b0, r0, a);
    M.xfer(8'hFF, 1'b1, r1, a);
    M.scl_pull <= 1'b1;
    M.w(8);
    check({7'h00, sda_oe}, 8'h00, "released after no-ack");
    check(8'(rd_cnt - n), 8'h02, "register fetches per read");
    M.cond(1'b1);
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_seq;
    logic [7:0] r0;
    logic [7:0] r1;
    wr2(8'h10, 8'hA5, 8'h5A);
    check(mem[8'h11], 8'h5A, "second written byte");
    check(reg_addr, 8'h12, "counter after write");
    rd2(8'h10, r0, r1);
    check(r0, 8'hA5, "first read byte");
    check(r1, 8'h5A, "second read byte");
  endtask

  task automatic t_hold;
    logic [7:0] r0;
    logic [7:0] r1;
    wr2(8'h21, 8'h11, 8'h3C);
    check(mem[8'h21], 8'h3C, "held write address");
    check(mem[8'h22], 8'h7E, "neighbour untouched");
    rd2(8'h21, r0, r1);
    check(r0, 8'h3C, "held read first byte");
    check(r1, 8'h3C, "held read repeats");
  endtask

  task automatic t_wrap;
    logic [7:0] r0;
    logic [7:0] r1;
    wr2(8'hFF, 8'hC3, 8'h24);
    check(mem[8'h00], 8'h24, "write wraps");
    rd2(8'hFF, r0, r1);
    check(r0, 8'hC3, "last address read");
    check(r1, 8'h24, "read wraps");
  endtask

  // Wrong address, then bytes after a stop with no new start.
  task automatic t_abuse;
    logic [7:0] rx;
    logic a;
    logic b;
    int n;
    n = wr_cnt;
    M.cond(1'b0);
    M.xfer({own ^ 7'h01, 1'b0}, 1'b1, rx, a);
    M.xfer(8'h30, 1'b1, rx, b);
    M.xfer(8'h99, 1'b1, rx, b);
    M.cond(1'b1);
    check({7'h00, a}, 8'h01, "foreign address");
    M.xfer({own, 1'b0}, 1'b1, rx, a);
    M.xfer(8'h30, 1'b1, rx, b);
    M.xfer(8'h99, 1'b1, rx, b);
    check({7'h00, a}, 8'h01, "no start");
    check(8'(wr_cnt - n), 8'h00, "nothing stored");
    M.cond(1'b1);
  endtask

  task automatic t_strap;
    strap <= 1'b1;
    wr2(8'h30, 8'h01, 8'h02);
    resetn <= 1'b0;
    M.w(12);
    resetn <= 1'b1;
    M.w(10);
    own = 7'h41;
    wr2(8'h30, 8'h03, 8'h04);
    check(mem[8'h30], 8'h03, "strap high address");
  endtask

  // Standard-mode phases of 5 us each.
  task automatic t_std;
    M.lo = 50;
    M.hi = 50;
    wr2(8'h40, 8'h66, 8'h77);
    check(mem[8'h41], 8'h77, "standard mode write");
  endtask

  // Reset for 12 cycles, then every scenario in turn.
  initial
  begin
    resetn = 1'b0;
    strap = 1'b0;
    own = 7'h40;
    err_count = 0;
    checked = 0;
    wr_cnt = 0;
    rd_cnt = 0;
    for (int i = 0; i < 256; i++)
      mem[i] = 8'(i) ^ 8'h5C;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    repeat (10) @(posedge clk);
    t_seq;
    t_hold;
    t_wrap;
    t_abuse;
    t_strap;
    t_std;
    close_out;
  end

  // The whole run needs about 14000 cycles; this limit leaves ample margin.
  initial
  begin
    repeat (40000) @(posedge clk);
    err_count++;
    close_out;
  end
endmodule // tsc_i2c_slave_bench
